// [hdl/sls_defines.vh]
`ifndef SLS_DEFINES_VH
`define SLS_DEFINES_VH
`define SLS_NUM_CH          12
`define SLS_AUTO_GROUP      6
`define SLS_CUR_USE_NORMAL  4'hF
`define SLS_ADCSEL_HIGHEST_OUTPUT_SELECT   4'h5
`define SLS_ERR_PULSE_US    13'h0032
`define SLS_CLK_MHZ         13'h0064
`define SLS_ERR_PULSE_CYC   (`SLS_ERR_PULSE_US * `SLS_CLK_MHZ)
`define SLS_PW_UNIT_CYC     16'h0064
`endif

// [hdl/sls_single_led_short_scan.v]
`timescale 1ns/100ps
`include "sls_defines.vh"
module sls_single_led_short_scan
(
	input  wire        core_clk,             // System clock
	input  wire        rstn,                 // Async reset, active low
	input  wire        offstateScanStart,    // Host write of 1 to start bit
	input  wire        autoScanEnable,       // Automatic scan enable
	input  wire [11:0] channelEnable,        // Per-channel enable
	input  wire [3:0]  diagPulseCurrent,     // Diagnostic current code
	input  wire [7:0]  diagPulseWidth,       // Pulse width / settle delay units
	input  wire [7:0]  shortThresholdCode,   // Short threshold code
	input  wire [3:0]  adcChannelSelect,     // Host ADC channel select
	input  wire        faultClearBit,        // Host write of 1 to clear
	input  wire        pwmRise,              // PWM rising edge, one cycle
	input  wire        supplyLow,            // Supply below low threshold
	input  wire        hostAdcRequest,       // Host on-demand ADC request pulse
	input  wire        adcDone,              // Converter done pulse
	input  wire [7:0]  adcData,              // Converter result
	output reg         adcStart,             // Converter start pulse
	output reg  [3:0]  adcMux,               // Converter channel
	output reg         hostAdcService,       // Host conversion in flight
	output reg  [7:0]  adcResult,            // Result shown to host
	output reg  [11:0] diagPulseEnable,      // Per-channel diagnostic pulse
	output reg         diagUseNormalCurrent, // Use channel current setting
	output reg  [3:0]  diagCurrentLevel,     // Dedicated diag current code
	output reg         startBitState,        // Start bit readback
	output reg         ondemandDoneFlag,     // On-demand done flag
	output reg  [11:0] channelDiagFaultFlag, // Per-channel fault flags
	output reg         outFaultFlag,         // Output summary flag
	output reg         errFlag,              // Global error flag
	output reg         errPinOe,             // Error pin sink enable
	output wire        errPinOut             // Error pin drive level
);
	reg [2:0]  stateReg;
	reg [3:0]  chReg;
	reg        autoModeReg;
	reg        autoHalfReg;
	reg [15:0] timerReg;
	reg [11:0] hitReg;
	reg [7:0]  maxReg;
	reg        pendReg;
	reg [12:0] errCntReg;
	reg        reportPulse;
	reg [11:0] reportMask;

	// Sequencer states
	localparam [2:0] ST_IDLE     = 3'h0;
	localparam [2:0] ST_PULSE    = 3'h1;
	localparam [2:0] ST_CONV     = 3'h2;
	localparam [2:0] ST_NEXT     = 3'h3;
	localparam [2:0] ST_SUPPLY   = 3'h4;
	localparam [2:0] ST_AUTOWAIT = 3'h5;
	localparam [2:0] ST_OD_ADC   = 3'h6;

	assign errPinOut = 1'b0;

	// Unit of 1 us; the extra cycle lets a zero code still pulse
	function [15:0] pwCycles;
		input [7:0] pw;
		begin
			pwCycles = {8'h00, pw} * `SLS_PW_UNIT_CYC + 16'h0001;
		end
	endfunction

	// Next enabled channel in the active auto group, 4'hF when none
	function [3:0] nextAuto;
		input [3:0]  from;
		input [11:0] en;
		input        half;
		integer i;
		reg [3:0] lo;
		begin
			nextAuto = 4'hF;
			lo = half ? 4'h6 : 4'h0;
			for (i = 11; i >= 0; i = i - 1)
				if (i >= from && i >= lo && i < lo + `SLS_AUTO_GROUP && en[i])
					nextAuto = i[3:0];
		end
	endfunction

	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stateReg <= ST_IDLE;
			chReg <= 4'h0;
			autoModeReg <= 1'b0;
			autoHalfReg <= 1'b0;
			timerReg <= 16'h0000;
			hitReg <= 12'h000;
			maxReg <= 8'h00;
			pendReg <= 1'b0;
			adcStart <= 1'b0;
			adcMux <= 4'h0;
			hostAdcService <= 1'b0;
			adcResult <= 8'h00;
			diagPulseEnable <= 12'h000;
			diagUseNormalCurrent <= 1'b0;
			diagCurrentLevel <= 4'h0;
			startBitState <= 1'b0;
			ondemandDoneFlag <= 1'b0;
			reportPulse <= 1'b0;
			reportMask <= 12'h000;
		end
		else
		begin
			adcStart <= 1'b0;
			reportPulse <= 1'b0;
			startBitState <= offstateScanStart;
			diagUseNormalCurrent <= (diagPulseCurrent == `SLS_CUR_USE_NORMAL);
			diagCurrentLevel <= diagPulseCurrent;
			if (hostAdcRequest)
				pendReg <= 1'b1;
			case (stateReg)
			ST_IDLE:
			begin
				if (offstateScanStart)
				begin
					ondemandDoneFlag <= 1'b0;
					autoModeReg <= 1'b0;
					chReg <= 4'h0;
					hitReg <= 12'h000;
					diagPulseEnable <= 12'h001;
					timerReg <= pwCycles(diagPulseWidth);
					stateReg <= ST_PULSE;
				end
				else if (autoScanEnable && pwmRise)
				begin
					autoModeReg <= 1'b1;
					if (!autoHalfReg)
					begin
						hitReg <= 12'h000;
						maxReg <= 8'h00;
					end
					chReg <= nextAuto(autoHalfReg ? 4'h6 : 4'h0, channelEnable, autoHalfReg);
					timerReg <= pwCycles(diagPulseWidth);
					stateReg <= ST_AUTOWAIT;
				end
				else if (pendReg || hostAdcRequest)
				begin
					pendReg <= 1'b0;
					adcMux <= adcChannelSelect;
					adcStart <= 1'b1;
					hostAdcService <= 1'b1;
					stateReg <= ST_OD_ADC;
				end
			end
			ST_AUTOWAIT:
			begin
				// Settle delay first, then one conversion per enabled channel
				if (timerReg != 16'h0000)
					timerReg <= timerReg - 16'h0001;
				else if (chReg == 4'hF)
					stateReg <= ST_SUPPLY;
				else
				begin
					adcMux <= chReg;
					adcStart <= 1'b1;
					stateReg <= ST_CONV;
				end
			end
			ST_PULSE:
			begin
				if (timerReg != 16'h0000)
					timerReg <= timerReg - 16'h0001;
				else
				begin
					diagPulseEnable <= 12'h000;
					adcMux <= chReg;
					adcStart <= 1'b1;
					stateReg <= ST_CONV;
				end
			end
			ST_CONV:
			begin
				if (adcDone)
				begin
					if (adcData < shortThresholdCode)
						hitReg[chReg] <= 1'b1;
					if (autoModeReg && adcData > maxReg)
						maxReg <= adcData;
					stateReg <= ST_NEXT;
				end
			end
			ST_NEXT:
			begin
				if (autoModeReg)
				begin
					chReg <= nextAuto(chReg + 4'h1, channelEnable, autoHalfReg);
					timerReg <= 16'h0000;
					stateReg <= (nextAuto(chReg + 4'h1, channelEnable, autoHalfReg) == 4'hF)
						? ST_SUPPLY : ST_AUTOWAIT;
				end
				else if (chReg == 4'd11)
					stateReg <= ST_SUPPLY;
				else
				begin
					chReg <= chReg + 4'h1;
					diagPulseEnable <= 12'h001 << (chReg + 4'h1);
					timerReg <= pwCycles(diagPulseWidth);
					stateReg <= ST_PULSE;
				end
			end
			ST_SUPPLY:
			begin
				// Low supply means low dropout, so results are not trusted
				if (!supplyLow && hitReg != 12'h000)
				begin
					reportPulse <= 1'b1;
					reportMask <= hitReg;
				end
				if (autoModeReg)
				begin
					autoHalfReg <= ~autoHalfReg;
					// Maximum spans both halves, so it is shown after the second
					if (autoHalfReg && adcChannelSelect == `SLS_ADCSEL_HIGHEST_OUTPUT_SELECT)
						adcResult <= maxReg;
					hitReg <= autoHalfReg ? 12'h000 : hitReg;
				end
				else
					ondemandDoneFlag <= 1'b1;
				stateReg <= ST_IDLE;
			end
			ST_OD_ADC:
			begin
				// Host conversions start only from idle, never inside a scan
				if (adcDone)
				begin
					adcResult <= adcData;
					hostAdcService <= 1'b0;
					stateReg <= ST_IDLE;
				end
			end
			default:
				stateReg <= ST_IDLE;
			endcase
			if (!autoScanEnable)
				autoHalfReg <= 1'b0;
		end
	end

	// Flags: a new report wins over a clear in the same cycle
	always @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			channelDiagFaultFlag <= 12'h000;
			outFaultFlag <= 1'b0;
			errFlag <= 1'b0;
			errCntReg <= 13'h0000;
			errPinOe <= 1'b0;
		end
		else
		begin
			if (faultClearBit)
			begin
				channelDiagFaultFlag <= 12'h000;
				outFaultFlag <= 1'b0;
				errFlag <= 1'b0;
			end
			if (reportPulse)
			begin
				channelDiagFaultFlag <= (faultClearBit ? 12'h000 : channelDiagFaultFlag)
					| reportMask;
				outFaultFlag <= 1'b1;
				errFlag <= 1'b1;
			end
			// A pulse in flight is not stretched: the pin already shows a fault
			if (reportPulse && errCntReg == 13'h0000)
			begin
				errCntReg <= `SLS_ERR_PULSE_CYC;
				errPinOe <= 1'b1;
			end
			else if (errCntReg != 13'h0000)
			begin
				errCntReg <= errCntReg - 13'h0001;
				errPinOe <= (errCntReg != 13'h0001);
			end
		end
	end
endmodule // sls_single_led_short_scan

// [bench/sls_scan_monitor.sv]
`timescale 1ns/100ps
module sls_scan_monitor
(
	input wire        core_clk,             // Clock
	input wire        rstn,                 // Reset, active low
	input wire        autoScanEnable,       // Auto scan enable
	input wire        faultClearBit,        // Fault clear
	input wire        supplyLow,            // Low supply
	input wire [11:0] channelEnable,        // Channel enables
	input wire [11:0] diagPulseEnable,      // Pulse outputs
	input wire [11:0] channelDiagFaultFlag, // Fault flags
	input wire [3:0]  diagPulseCurrent,     // Current code
	input wire [3:0]  adcMux,               // Converter channel
	input wire        adcStart,             // Converter start
	input wire        hostAdcService,       // Host conversion busy
	input wire        diagUseNormalCurrent, // Normal current chosen
	input wire        startBitState,        // Start bit readback
	input wire        ondemandDoneFlag,     // Done flag
	input wire        errFlag,              // Global error flag
	input wire        outFaultFlag,         // Summary flag
	input wire        errPinOe              // Error pin sink
);
	reg [12:0] errCnt_reg;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	always @(posedge core_clk or negedge rstn)
		if (!rstn)
			errCnt_reg <= 13'h0000;
		else
			errCnt_reg <= errPinOe ? errCnt_reg + 13'h0001 : 13'h0000;
	a_start_self_clear: assert property (startBitState |=> !startBitState)
		else $error("start bit stuck");
	a_done_cleared: assert property ($rose(startBitState) |=> !ondemandDoneFlag)
		else $error("done flag not cleared");
	a_pulse_single: assert property ($onehot0(diagPulseEnable))
		else $error("two pulses at once");
	a_err_width: assert property ($fell(errPinOe) |-> errCnt_reg == 13'h1388)
		else $error("error pulse width");
	a_err_flags: assert property ($rose(errPinOe) |-> ##[0:1] (errFlag && outFaultFlag))
		else $error("flags missing on report");
	a_low_supply_quiet: assert property ($rose(errPinOe) |-> !$past(supplyLow))
		else $error("report under low supply");
	a_flags_latched: assert property ($fell(errFlag) |-> $past(faultClearBit))
		else $error("flag dropped without clear");
	a_normal_current: assert property (diagPulseEnable != 12'h000
		|-> diagUseNormalCurrent == (diagPulseCurrent == 4'hF))
		else $error("current source choice");
	a_host_held: assert property ($rose(hostAdcService) |-> diagPulseEnable == 12'h000)
		else $error("host conversion during scan");
	a_auto_skip: assert property (adcStart && autoScanEnable && !hostAdcService && adcMux < 4'hC
		|-> channelEnable[adcMux])
		else $error("disabled channel scanned");
endmodule // sls_scan_monitor
bind sls_single_led_short_scan sls_scan_monitor sls_scan_monitor_i (.*);

// [bench/sls_adc_model.sv]
`timescale 1ns/100ps
module sls_adc_model
(
	input wire       clk,     // Clock
	input wire       adcStart, // Start pulse
	input wire [3:0] adcMux,  // Channel
	output reg       adcDone, // Done pulse
	output reg [7:0] adcData  // Result
);
	reg [7:0] volt [0:15];
	reg [7:0] v;
	initial
	begin
		adcDone = 1'b0;
		adcData = 8'h5A;
		forever
		begin
			@(posedge clk);
			if (adcStart === 1'b1)
			begin
				v = volt[adcMux];
				repeat (2 + $urandom % 4) @(posedge clk);
				adcDone <= 1'b1;
				adcData <= v;
				@(posedge clk);
				adcDone <= 1'b0;
				adcData <= ~v; // Released data is not left valid
			end
		end
	end
endmodule // sls_adc_model

// [bench/sls_single_led_short_scan_test.sv]
`timescale 1ns/100ps
`include "sls_defines.vh"
module sls_single_led_short_scan_test;
	reg clk = 0, rstn = 0, start = 0, autoEn = 0, clr = 0, pwm = 0, low = 0, hreq = 0;
	reg hostEarly = 0;
	reg [11:0] en = 12'h000;
	reg [3:0] cur = 4'hF, sel = 4'h0, q [$];
	reg [7:0] pw = 8'h01, thr = 8'h00, mx, vol [0:11];
	wire adcDone, adcStart, hsvc, done, errF, outF, oe;
	wire [7:0] adcData, res;
	wire [3:0] mux;
	wire [11:0] flags;
	int n_fail = 0, n_tests = 0, k, j;
	sls_adc_model sls_adc_model_i (.clk(clk), .adcStart(adcStart), .adcMux(mux),
		.adcDone(adcDone), .adcData(adcData));
	sls_single_led_short_scan sls_single_led_short_scan_i (.core_clk(clk), .rstn(rstn),
		.offstateScanStart(start), .autoScanEnable(autoEn), .channelEnable(en),
		.diagPulseCurrent(cur), .diagPulseWidth(pw), .shortThresholdCode(thr),
		.adcChannelSelect(sel), .faultClearBit(clr), .pwmRise(pwm), .supplyLow(low),
		.hostAdcRequest(hreq), .adcDone(adcDone), .adcData(adcData), .adcStart(adcStart),
		.adcMux(mux), .hostAdcService(hsvc), .adcResult(res), .diagPulseEnable(),
		.diagUseNormalCurrent(), .diagCurrentLevel(), .startBitState(),
		.ondemandDoneFlag(done), .channelDiagFaultFlag(flags), .outFaultFlag(outF),
		.errFlag(errF), .errPinOe(oe), .errPinOut());
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (adcStart === 1'b1 && hsvc !== 1'b1) q.push_back(mux);
	always @(posedge clk) if (hsvc === 1'b1 && done !== 1'b1) hostEarly <= 1'b1;
	task chk(input [31:0] g, input [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task waitFor(input int lim, input bit lvl, input int which);
		for (k = 0; k < lim && (which == 1 ? hsvc : which == 0 ? done : oe) !== lvl; k++)
			@(posedge clk);
		#1;
		if (k == lim)
		begin
			n_fail++;
			results;
		end
	endtask
	task scan;
		q.delete();
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		@(posedge clk) #1 chk(done, 0);
		waitFor(4000, 1, 0);
	endtask
	function [11:0] expf(input [11:0] m);
		for (j = 0; j < 12; j++) expf[j] = m[j] && vol[j] < thr;
	endfunction
	initial
	begin
		void'($urandom(33));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		thr <= 8'd20 + $urandom % 200;
		#1 for (j = 0; j < 12; j++) vol[j] = $urandom;
		vol[3] = thr - 8'h01;
		vol[4] = thr;
		for (j = 0; j < 16; j++) sls_adc_model_i.volt[j] = j < 12 ? vol[j] : 8'h00;
		scan();
		chk(q.size(), 12);
		for (j = 0; j < 12; j++) chk(q[j], j);
		chk(flags, expf(12'hFFF));
		waitFor(6000, 0, -1);
		chk({errF, outF, flags[3], flags[4]}, 4'hE);
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		@(posedge clk) #1 chk({errF, outF, flags}, 0);
		$display("offstate scan done");
		low <= 1'b1;
		cur <= $urandom % 15;
		sel <= 4'h2;
		q.delete();
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		@(posedge clk) hreq <= 1'b1;
		@(posedge clk) hreq <= 1'b0;
		#1 chk(done, 0);
		waitFor(4000, 1, 0);
		chk({errF, flags, oe}, 0);
		chk(hostEarly, 0);
		waitFor(200, 1, 1);
		waitFor(200, 0, 1);
		chk(res, vol[2]);
		$display("low supply scan done");
		low <= 1'b0;
		en <= $urandom | 12'h081;
		autoEn <= 1'b1;
		sel <= `SLS_ADCSEL_HIGHEST_OUTPUT_SELECT;
		q.delete();
		vol[7] = 8'h00;
		sls_adc_model_i.volt[7] = 8'h00;
		repeat (2)
		begin
			@(posedge clk) pwm <= 1'b1;
			@(posedge clk) pwm <= 1'b0;
			repeat (700) @(posedge clk);
		end
		#1 j = 0;
		for (k = 0; k < 12; k++) if (en[k]) chk(q[j++], k);
		chk(flags, expf(en));
		mx = 8'h00;
		for (k = 0; k < 12; k++) if (en[k] && vol[k] > mx) mx = vol[k];
		chk(res, mx);
		$display("auto scan done");
		results;
	end
endmodule // sls_single_led_short_scan_test
